// *** bench/dma_core_chk.sv ***
// Purpose: port assertions for the dma core
// Assumes: one clock domain, async active-low reset
// Notes:   bound onto every core instance
module dma_core_chk import dma_core_pkg::*; #(
    parameter logic [15:0] PROG_ONCHIP_LIMIT = 16'h4000
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire mmr_req_t mmr_i,
    input wire logic [15:0] mmr_rdata_o,
    input wire logic rd_req_o,
    input wire mem_req_t rd_o,
    input wire logic rd_ack_i,
    input wire logic wr_req_o,
    input wire xfer_t wr_o,
    input wire logic wr_ack_i,
    input wire logic cpu_req_i,
    input wire logic cpu_hold_o
);
    timeunit 1ns / 1ns;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    // requests stay put until answered, else the far side sees torn data
    chk_rd_hold: assert property (rd_req_o && !rd_ack_i |=> rd_req_o && $stable(rd_o))
        else $error("read request moved");
    chk_wr_hold: assert property (wr_req_o && !wr_ack_i |=> wr_req_o && $stable(wr_o))
        else $error("write request moved");
    chk_space_legal: assert property (wr_req_o |-> wr_o.dst.space != SPACE_RESERVED)
        else $error("reserved space written");
    chk_prog_ext:
        assert property (rd_req_o && rd_o.space == SPACE_PROGRAM
            && rd_o.addr >= PROG_ONCHIP_LIMIT |-> rd_o.ext) else $error("read not external");
    chk_sc_reads:
        assert property (mmr_i.re && mmr_i.addr == OFS_SET_CLEAR |=> mmr_rdata_o == 16'h0000)
        else $error("set/clear readable");
    chk_read_gap: assert property (rd_ack_i |=> !rd_req_o) else $error("read overlap");
    chk_cpu_wait: assert property (cpu_req_i && rd_req_o |=> cpu_hold_o)
        else $error("cpu not held");
    chk_cpu_free: assert property (!cpu_req_i |=> !cpu_hold_o) else $error("idle cpu held");
endmodule : dma_core_chk
////////////////////////////////////////////////////////////////////////////////////////////////
bind multichannel_dma_core dma_core_chk #(.PROG_ONCHIP_LIMIT(PROG_ONCHIP_LIMIT)) u_dma_core_chk (
    .clk_sys_i, .arst_n_i, .mmr_i, .mmr_rdata_o, .rd_req_o, .rd_o, .rd_ack_i, .wr_req_o,
    .wr_o, .wr_ack_i, .cpu_req_i, .cpu_hold_o);

// *** bench/dma_mem_model.sv ***
// Purpose: memory buses on the far side of the dma core
// Assumes: one answer per request, writes can be stalled
// Notes:   read data is the address xor a fixed mask
module dma_mem_model import dma_core_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic rd_req_i,
    input wire mem_req_t rd_i,
    input wire logic wr_req_i,
    input wire xfer_t wr_i,
    input wire logic stall_i,
    output logic rd_ack_o,
    output logic [15:0] rd_data_o,
    output logic wr_ack_o,
    output logic [15:0] n_wr_o,
    output xfer_t last_wr_o,
    output logic rd_ext_o
);
    timeunit 1ns / 1ns;
    // data line toggles between answers so a stale sample never matches
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {rd_ack_o, rd_data_o, rd_ext_o, wr_ack_o, n_wr_o, last_wr_o} <= '0;
        end else begin
            rd_ack_o <= rd_req_i && !rd_ack_o;
            rd_data_o <= (rd_req_i && !rd_ack_o) ? (rd_i.addr ^ 16'hA5A5) : ~rd_data_o;
            rd_ext_o <= rd_req_i ? rd_i.ext : rd_ext_o;
            wr_ack_o <= wr_req_i && !wr_ack_o && !stall_i;
            n_wr_o <= n_wr_o + 16'(wr_req_i && wr_ack_o);
            last_wr_o <= (wr_req_i && wr_ack_o) ? wr_i : last_wr_o;
        end
    end
endmodule : dma_mem_model

// *** bench/multichannel_dma_core_tb_top.sv ***
// Purpose: register-level tests of the dma core
// Assumes: model answers every request
// Notes:   channels 1-5 parked on a reserved space code
module multichannel_dma_core_tb_top import dma_core_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 0, arst_n_i = 0, cpu_req_i = 0, stall = 0, rd_req_o, rd_ack_i;
    logic wr_req_o, wr_ack_i, cpu_hold_o, rd_ext;
    logic [15:0] mmr_rdata_o, rd_data_i, n_wr;
    logic [5:0] block_done_o;
    mmr_req_t mmr_i = '0;
    mem_req_t rd_o;
    xfer_t wr_o, last_wr;
    int num_errors = 0, num_checks = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    multichannel_dma_core u_multichannel_dma_core (.clk_sys_i, .arst_n_i, .mmr_i, .mmr_rdata_o,
        .rd_req_o, .rd_o, .rd_ack_i, .rd_data_i, .wr_req_o, .wr_o, .wr_ack_i, .cpu_req_i,
        .cpu_hold_o, .block_done_o);
    dma_mem_model u_dma_mem_model (.clk_sys_i, .arst_n_i, .rd_req_i(rd_req_o), .rd_i(rd_o),
        .wr_req_i(wr_req_o), .wr_i(wr_o), .stall_i(stall), .rd_ack_o(rd_ack_i),
        .rd_data_o(rd_data_i), .wr_ack_o(wr_ack_i), .n_wr_o(n_wr), .last_wr_o(last_wr),
        .rd_ext_o(rd_ext));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    // strobe for one edge, dropped at the taking edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        mmr_i <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        mmr_i <= '0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys_i);
        mmr_i <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_sys_i);
        mmr_i <= '0;
        @(negedge clk_sys_i);
        check(mmr_rdata_o, exp);
    endtask : rd_chk
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        int t, nd;
        logic [15:0] src;
        repeat (10) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        for (int c = 1; c < 6; c++) wr(8'(8'h44 + c * 16), 16'h0003);
        wr(OFS_SET_CLEAR, 16'h803E);
        rd_chk(OFS_PRIORITY_ENABLE, 16'h003E);
        rd_chk(OFS_SET_CLEAR, 16'h0000);
        wr(OFS_SET_CLEAR, 16'h7FC2);
        rd_chk(OFS_PRIORITY_ENABLE, 16'h003C);
        // one block of 20 words per destination space, writes stalled to fill the fifo
        for (int i = 0; i < 3; i++) begin
            src = (i == 0) ? 16'h4010 : 16'h0010;
            wr(8'h40, src);
            wr(8'h41, 16'h0200);
            wr(8'h42, 16'h0013);
            wr(8'h43, 16'h0000);
            wr(8'h44, 16'h0104 | 16'(i) | (i == 2 ? 16'h0820 : 16'h0000));
            stall <= 1'b1;
            cpu_req_i <= i[0];
            wr(OFS_SET_CLEAR, 16'h8001);
            repeat (60) @(posedge clk_sys_i);
            stall <= 1'b0;
            for (t = 0; t < 4000 && n_wr !== 16'(20 * i + 20); t++)
                @(negedge clk_sys_i) nd += block_done_o[0];
            if (t == 4000) begin
                num_errors++;
                $display("Error at %0t: block hung", $time);
                stop_test();
            end
            check(last_wr.data, (src + 16'h0013) ^ 16'hA5A5);
            check(last_wr.dst.addr, 16'h0213);
            check(16'(last_wr.dst.space), 16'(i));
            check(16'(last_wr.dst.ext), 16'(i == 2));
            check(16'(rd_ext), 16'(i != 1));
            check(16'(nd), 16'(i + 1));
            rd_chk(OFS_PRIORITY_ENABLE, 16'h003C);
        end
        stop_test();
    end
endmodule : multichannel_dma_core_tb_top

// *** inc/dma_core_pkg.sv ***
// Purpose: shared constants, types and register map of the six-channel dma core
// Assumes: 16-bit word-addressed memory-mapped register port, word-wide memories
// Notes:   channel register n, field k sits at CH_BASE + n*16 + k

package dma_core_pkg;

    localparam int NUM_CHANNELS = 6;
    localparam int WORD_W = 16;
    localparam int MMR_ADDR_W = 8;
    localparam int XFER_FIFO_DEPTH = 16;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] OFS_ELEMENT_INDEX = 8'h3A;
    localparam logic [7:0] OFS_SET_CLEAR = 8'h3E;
    localparam logic [7:0] OFS_PRIORITY_ENABLE = 8'h3F;
    localparam logic [3:0] CH_BLOCK_FIRST = 4'h4;
    localparam logic [3:0] SUB_SRC = 4'h0;
    localparam logic [3:0] SUB_DST = 4'h1;
    localparam logic [3:0] SUB_ELEM_CNT = 4'h2;
    localparam logic [3:0] SUB_FRAME_CNT = 4'h3;
    localparam logic [3:0] SUB_MODE = 4'h4;
    localparam logic [3:0] SUB_SRC_RELOAD = 4'h5;
    localparam logic [3:0] SUB_DST_RELOAD = 4'h6;
    localparam logic [3:0] SUB_CNT_RELOAD = 4'h7;
    localparam logic [3:0] SUB_FRAME_RELOAD = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // transfer_mode_control fields
    localparam int MODE_AUTO_BIT = 15;
    localparam int MODE_DWORD_BIT = 12;
    localparam int MODE_SRC_EXT_BIT = 11;
    localparam int MODE_SRC_ADJ_LO = 8;
    localparam int MODE_SRC_SPACE_LO = 6;
    localparam int MODE_DST_EXT_BIT = 5;
    localparam int MODE_DST_ADJ_LO = 2;
    localparam int MODE_DST_SPACE_LO = 0;

    // priority_enable_reg and channel_enable_set_clear fields
    localparam int PE_ENABLE_LO = 0;
    localparam int PE_RELOAD_SEL_BIT = 7;
    localparam int PE_PRIORITY_LO = 8;
    localparam int SC_OP_BIT = 15;
    localparam int SC_SELECT_LO = 0;

    // reset values
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] FRAME_RESET = 8'h00;

    typedef enum logic [1:0] {
        SPACE_PROGRAM = 2'b00,
        SPACE_DATA = 2'b01,
        SPACE_IO = 2'b10,
        SPACE_RESERVED = 2'b11
    } space_t;

    typedef enum logic [1:0] {
        ADJ_HOLD = 2'b00,
        ADJ_INC = 2'b01,
        ADJ_DEC = 2'b10,
        ADJ_INDEX = 2'b11
    } adj_t;

    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_BUSY = 1'b1
    } rd_state_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [MMR_ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } mmr_req_t;

    typedef struct packed {
        logic [WORD_W-1:0] addr;
        space_t space;
        logic ext;
    } mem_req_t;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        mem_req_t dst;
    } xfer_t;

endpackage : dma_core_pkg

// *** verilog/multichannel_dma_core.sv ***
// Purpose: six-channel dma engine with read port, transfer fifo and write port
// Assumes: one read and one write outstanding at most, handshakes held until ack
// Notes:   counters hold count minus one, so 16'hFFFF means 65536 elements
//
// Function
// - destination external bit 5 routes writes out
// - source external bit 11 routes reads out
// - space codes program, data, io, reserved
// - program addresses beyond on-chip bound go external
// - enable set/clear register at 0x3E
// - bit 15 chooses set or clear
// - bits 5-0 pick channels, others untouched
// - set/clear register is write-only, reads zero
// - dma memory view ignores cpu map bits
// - high priority channels served before low
// - equal priority channels served round-robin
// - per-side post inc, dec or index
// - auto mode reloads addresses and counts, continues
// - every channel owns a reload register set
// - reload select bit picks channel-0 or own
// - 8-bit frame counter drops on last read
// - frame counter reloads only with auto bit
// - frame count zero means single frame
// - 16-bit element counter drops after each element
// - element counter reloads after each frame, the last only with auto bit
// - doubleword moves two words as one element
// - one external reader, one external writer channel
// - dma wins bus, cpu held with waits

////////////////////////////////////////////////////////////////////////////////////////////////
// transfer fifo between read side and write side
module dma_xfer_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] fill;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = (fill != (AW+1)'(DEPTH)); // honest full stalls the read side
    assign out_valid_o = (fill != '0);
    assign out_data_o = mem[rd_ptr];

    // storage, no reset needed on data words
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
            end
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dma_xfer_fifo

////////////////////////////////////////////////////////////////////////////////////////////////
module multichannel_dma_core import dma_core_pkg::*; #(
    parameter int NUM_CH = NUM_CHANNELS,
    parameter int FIFO_DEPTH = XFER_FIFO_DEPTH,
    parameter logic [15:0] PROG_ONCHIP_LIMIT = 16'h4000
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire mmr_req_t mmr_i,
    output logic [15:0] mmr_rdata_o,
    output logic rd_req_o,
    output mem_req_t rd_o,
    input wire logic rd_ack_i,
    input wire logic [15:0] rd_data_i,
    output logic wr_req_o,
    output xfer_t wr_o,
    input wire logic wr_ack_i,
    input wire logic cpu_req_i,
    output logic cpu_hold_o,
    output logic [NUM_CH-1:0] block_done_o
);
    localparam int CW = $clog2(NUM_CH);

    // working and reload registers per channel
    logic [15:0] src_addr [NUM_CH];
    logic [15:0] dst_addr [NUM_CH];
    logic [15:0] element_counter [NUM_CH];
    logic [7:0] frame_counter [NUM_CH];
    logic [15:0] transfer_mode_control [NUM_CH];
    logic [15:0] source_reload [NUM_CH];
    logic [15:0] dest_reload [NUM_CH];
    logic [15:0] element_count_reload [NUM_CH];
    logic [7:0] frame_count_reload [NUM_CH];
    logic [NUM_CH-1:0] dword_half;
    logic [15:0] element_index;

    // priority_enable_reg fields
    logic [NUM_CH-1:0] channel_enable_bit;
    logic [NUM_CH-1:0] high_priority;
    logic reload_set_select;

    logic rd_ext_own_v;
    logic [CW-1:0] rd_ext_own;
    logic wr_ext_own_v;
    logic [CW-1:0] wr_ext_own;
    logic [CW-1:0] last_hi;
    logic [CW-1:0] last_lo;
    rd_state_t rd_state;
    logic [CW-1:0] cur_ch;
    mem_req_t cur_dst;

    // on-chip map is fixed; cpu map, rom-in-data and overlay bits never reach this logic
    function automatic logic is_external(logic sel, logic [1:0] space, logic [15:0] a);
        is_external = sel || (space == SPACE_PROGRAM && a >= PROG_ONCHIP_LIMIT);
    endfunction : is_external

    function automatic logic [15:0] adj_addr(logic [15:0] a, logic [1:0] m, logic [15:0] idx);
        case (m)
            ADJ_INC: adj_addr = a + 16'h0001;
            ADJ_DEC: adj_addr = a - 16'h0001;
            ADJ_INDEX: adj_addr = a + idx;
            default: adj_addr = a;
        endcase
    endfunction : adj_addr

    // returns {hit, channel} for a per-channel register address
    function automatic logic [CW:0] ch_decode(logic [7:0] a);
        logic [3:0] blk;
        blk = a[7:4] - CH_BLOCK_FIRST;
        ch_decode = {(a[7:4] >= CH_BLOCK_FIRST) && (blk < 4'(NUM_CH))
                     && (a[3:0] <= SUB_FRAME_RELOAD), blk[CW-1:0]};
    endfunction : ch_decode

    // round-robin pick starting after the last served channel
    function automatic logic [CW:0] rr_pick(logic [NUM_CH-1:0] req, logic [CW-1:0] last);
        int idx;
        rr_pick = '0;
        for (int i = NUM_CH; i >= 1; i--) begin
            idx = (int'(last) + i) % NUM_CH;
            if (req[idx]) begin
                rr_pick = {1'b1, CW'(idx)};
            end
        end
    endfunction : rr_pick

    ////////////////////////////////////////////////////////////////////////////////////////////
    // register port decode
    logic [CW:0] wr_dec;
    logic [CW:0] rd_dec;
    logic ch_wr;
    logic pe_wr;
    logic sc_wr;

    assign wr_dec = ch_decode(mmr_i.addr);
    assign rd_dec = wr_dec;
    assign ch_wr = mmr_i.we && wr_dec[CW];
    assign pe_wr = mmr_i.we && (mmr_i.addr == OFS_PRIORITY_ENABLE);
    assign sc_wr = mmr_i.we && (mmr_i.addr == OFS_SET_CLEAR);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // eligibility and arbitration
    logic [NUM_CH-1:0] src_ext_now;
    logic [NUM_CH-1:0] dst_ext_now;
    logic [NUM_CH-1:0] eligible;
    logic [CW:0] pick_hi;
    logic [CW:0] pick_lo;
    logic [CW:0] pick;
    logic [CW-1:0] pch;
    logic fifo_in_ready;
    logic fifo_out_valid;
    xfer_t fifo_out;
    logic grant;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_elig
        logic [15:0] m;
        assign m = transfer_mode_control[g];
        assign src_ext_now[g] = is_external(m[MODE_SRC_EXT_BIT],
                                            m[MODE_SRC_SPACE_LO +: 2], src_addr[g]);
        assign dst_ext_now[g] = is_external(m[MODE_DST_EXT_BIT],
                                            m[MODE_DST_SPACE_LO +: 2], dst_addr[g]);
        // reserved space codes never run; only the owning channel may go external
        assign eligible[g] = channel_enable_bit[g]
            && (m[MODE_SRC_SPACE_LO +: 2] != SPACE_RESERVED)
            && (m[MODE_DST_SPACE_LO +: 2] != SPACE_RESERVED)
            && (!src_ext_now[g] || !rd_ext_own_v || rd_ext_own == CW'(g))
            && (!dst_ext_now[g] || !wr_ext_own_v || wr_ext_own == CW'(g));
    end

    assign pick_hi = rr_pick(eligible & high_priority, last_hi);
    assign pick_lo = rr_pick(eligible & ~high_priority, last_lo);
    assign pick = pick_hi[CW] ? pick_hi : pick_lo;
    assign pch = pick[CW-1:0];
    // one read in flight, so room at grant means room at the ack
    assign grant = (rd_state == RD_IDLE) && pick[CW] && fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // completion of the element being read
    logic rd_done;
    logic [15:0] cur_mode;
    logic elem_end;
    logic frame_end;
    logic block_end;
    logic [CW-1:0] rs;
    logic [NUM_CH-1:0] hw_clear;
    logic [NUM_CH-1:0] done_vec;

    assign rd_done = (rd_state == RD_BUSY) && rd_ack_i;
    assign cur_mode = transfer_mode_control[cur_ch];
    assign elem_end = !cur_mode[MODE_DWORD_BIT] || dword_half[cur_ch];
    assign frame_end = elem_end && (element_counter[cur_ch] == 16'h0000);
    assign block_end = frame_end && (frame_counter[cur_ch] == 8'h00);
    assign rs = reload_set_select ? cur_ch : '0;
    assign done_vec = (rd_done && block_end) ? (NUM_CH'(1) << cur_ch) : '0;
    assign hw_clear = cur_mode[MODE_AUTO_BIT] ? '0 : done_vec;

    // read side state
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_state <= RD_IDLE;
            rd_req_o <= 1'b0;
            rd_o <= '0;
            cur_ch <= '0;
            cur_dst <= '0;
            last_hi <= CW'(NUM_CH-1);
            last_lo <= CW'(NUM_CH-1);
        end else begin
            if (grant) begin
                rd_state <= RD_BUSY;
                rd_req_o <= 1'b1;
                cur_ch <= pch;
                rd_o.addr <= src_addr[pch];
                rd_o.space <= space_t'(transfer_mode_control[pch][MODE_SRC_SPACE_LO +: 2]);
                rd_o.ext <= src_ext_now[pch];
                cur_dst.addr <= dst_addr[pch];
                cur_dst.space <= space_t'(transfer_mode_control[pch][MODE_DST_SPACE_LO +: 2]);
                cur_dst.ext <= dst_ext_now[pch];
                if (pick_hi[CW]) begin
                    last_hi <= pch;
                end else begin
                    last_lo <= pch;
                end
            end else if (rd_done) begin
                rd_state <= RD_IDLE;
                rd_req_o <= 1'b0;
            end
        end
    end

    // external bus ownership, released once the owner is disabled and its side has drained
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_ext_own_v <= 1'b0;
            rd_ext_own <= '0;
            wr_ext_own_v <= 1'b0;
            wr_ext_own <= '0;
        end else begin
            if (grant && src_ext_now[pch]) begin
                rd_ext_own_v <= 1'b1;
                rd_ext_own <= pch;
            end else if (!channel_enable_bit[rd_ext_own] && rd_state == RD_IDLE) begin
                rd_ext_own_v <= 1'b0;
            end
            if (grant && dst_ext_now[pch]) begin
                wr_ext_own_v <= 1'b1;
                wr_ext_own <= pch;
            end else if (!channel_enable_bit[wr_ext_own] && !fifo_out_valid && !wr_req_o) begin
                wr_ext_own_v <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // channel registers: software writes take the cycle over engine updates
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                src_addr[c] <= WORD_RESET;
                dst_addr[c] <= WORD_RESET;
                element_counter[c] <= WORD_RESET;
                frame_counter[c] <= FRAME_RESET;
                transfer_mode_control[c] <= MODE_RESET;
                source_reload[c] <= WORD_RESET;
                dest_reload[c] <= WORD_RESET;
                element_count_reload[c] <= WORD_RESET;
                frame_count_reload[c] <= FRAME_RESET;
            end
            dword_half <= '0;
            element_index <= WORD_RESET;
        end else begin
            if (rd_done) begin
                src_addr[cur_ch] <= adj_addr(src_addr[cur_ch], cur_mode[MODE_SRC_ADJ_LO +: 2],
                                             element_index);
                dst_addr[cur_ch] <= adj_addr(dst_addr[cur_ch], cur_mode[MODE_DST_ADJ_LO +: 2],
                                             element_index);
                dword_half[cur_ch] <= cur_mode[MODE_DWORD_BIT] && !dword_half[cur_ch];
                if (elem_end && !frame_end) begin
                    element_counter[cur_ch] <= element_counter[cur_ch] - 16'h0001;
                end else if (frame_end && !block_end) begin
                    frame_counter[cur_ch] <= frame_counter[cur_ch] - 8'h01;
                    element_counter[cur_ch] <= element_count_reload[rs];
                end else if (block_end && cur_mode[MODE_AUTO_BIT]) begin
                    src_addr[cur_ch] <= source_reload[rs];
                    dst_addr[cur_ch] <= dest_reload[rs];
                    element_counter[cur_ch] <= element_count_reload[rs];
                    frame_counter[cur_ch] <= frame_count_reload[rs];
                end
            end
            if (mmr_i.we && mmr_i.addr == OFS_ELEMENT_INDEX) begin
                element_index <= mmr_i.wdata;
            end
            if (ch_wr) begin
                case (mmr_i.addr[3:0])
                    SUB_SRC: src_addr[wr_dec[CW-1:0]] <= mmr_i.wdata;
                    SUB_DST: dst_addr[wr_dec[CW-1:0]] <= mmr_i.wdata;
                    SUB_ELEM_CNT: element_counter[wr_dec[CW-1:0]] <= mmr_i.wdata;
                    SUB_FRAME_CNT: frame_counter[wr_dec[CW-1:0]] <= mmr_i.wdata[7:0];
                    SUB_MODE: transfer_mode_control[wr_dec[CW-1:0]] <= mmr_i.wdata;
                    SUB_SRC_RELOAD: source_reload[wr_dec[CW-1:0]] <= mmr_i.wdata;
                    SUB_DST_RELOAD: dest_reload[wr_dec[CW-1:0]] <= mmr_i.wdata;
                    SUB_CNT_RELOAD: element_count_reload[wr_dec[CW-1:0]] <= mmr_i.wdata;
                    default: frame_count_reload[wr_dec[CW-1:0]] <= mmr_i.wdata[7:0];
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // priority_enable_reg; completion clears first so no stray transfer follows
    logic [NUM_CH-1:0] sc_sel;
    logic [NUM_CH-1:0] en_kept;

    assign sc_sel = mmr_i.wdata[SC_SELECT_LO +: NUM_CH];
    assign en_kept = channel_enable_bit & ~hw_clear;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            channel_enable_bit <= '0;
            high_priority <= '0;
            reload_set_select <= 1'b0;
        end else begin
            if (pe_wr) begin
                // a set/clear set racing completion may re-arm a channel; a direct write avoids it
                channel_enable_bit <= mmr_i.wdata[PE_ENABLE_LO +: NUM_CH] & ~hw_clear;
                high_priority <= mmr_i.wdata[PE_PRIORITY_LO +: NUM_CH];
                reload_set_select <= mmr_i.wdata[PE_RELOAD_SEL_BIT];
            end else if (sc_wr && mmr_i.wdata[SC_OP_BIT]) begin
                channel_enable_bit <= en_kept | sc_sel;
            end else if (sc_wr) begin
                channel_enable_bit <= en_kept & ~sc_sel;
            end else begin
                channel_enable_bit <= en_kept;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // transfer fifo and write side
    xfer_t fifo_in;

    assign fifo_in.data = rd_data_i;
    assign fifo_in.dst = cur_dst;

    dma_xfer_fifo #(
        .WIDTH($bits(xfer_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(rd_done),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(!wr_req_o),
        .out_data_o(fifo_out)
    );

    // write request held until acknowledged; a full fifo stalls new grants
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_req_o <= 1'b0;
            wr_o <= '0;
        end else if (!wr_req_o && fifo_out_valid) begin
            wr_req_o <= 1'b1;
            wr_o <= fifo_out;
        end else if (wr_req_o && wr_ack_i) begin
            wr_req_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // register read data, cpu hold and completion pulses
    logic [15:0] rd_word;

    always_comb begin
        rd_word = 16'h0000; // unmapped and set/clear read as zero
        if (mmr_i.addr == OFS_PRIORITY_ENABLE) begin
            rd_word[PE_ENABLE_LO +: NUM_CH] = channel_enable_bit;
            rd_word[PE_PRIORITY_LO +: NUM_CH] = high_priority;
            rd_word[PE_RELOAD_SEL_BIT] = reload_set_select;
        end else if (mmr_i.addr == OFS_ELEMENT_INDEX) begin
            rd_word = element_index;
        end else if (rd_dec[CW]) begin
            case (mmr_i.addr[3:0])
                SUB_SRC: rd_word = src_addr[rd_dec[CW-1:0]];
                SUB_DST: rd_word = dst_addr[rd_dec[CW-1:0]];
                SUB_ELEM_CNT: rd_word = element_counter[rd_dec[CW-1:0]];
                SUB_FRAME_CNT: rd_word = {8'h00, frame_counter[rd_dec[CW-1:0]]};
                SUB_MODE: rd_word = transfer_mode_control[rd_dec[CW-1:0]];
                SUB_SRC_RELOAD: rd_word = source_reload[rd_dec[CW-1:0]];
                SUB_DST_RELOAD: rd_word = dest_reload[rd_dec[CW-1:0]];
                SUB_CNT_RELOAD: rd_word = element_count_reload[rd_dec[CW-1:0]];
                default: rd_word = {8'h00, frame_count_reload[rd_dec[CW-1:0]]};
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mmr_rdata_o <= 16'h0000;
            cpu_hold_o <= 1'b0;
            block_done_o <= '0;
        end else begin
            if (mmr_i.re) begin
                mmr_rdata_o <= rd_word;
            end
            cpu_hold_o <= cpu_req_i && (rd_req_o || wr_req_o || grant);
            block_done_o <= done_vec;
        end
    end

endmodule : multichannel_dma_core
